/* pkg/ebpfc_pkg.sv */
// Constants for the external bus pin function controller.
package ebpfc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] EBPFC_OFS_CS_OUT_EN   = 8'h00;
    localparam logic [7:0] EBPFC_OFS_CS_PIN_SEL  = 8'h04;
    localparam logic [7:0] EBPFC_OFS_UPPER_ADDR  = 8'h08;
    localparam logic [7:0] EBPFC_OFS_AREA_WIDTH  = 8'h0C;
    localparam logic [7:0] EBPFC_OFS_SYS_CTRL    = 8'h10;
    localparam logic [7:0] EBPFC_OFS_PIN_STATUS  = 8'h14;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int EBPFC_STROBES      = 8;
    localparam int EBPFC_UPPER_LINES  = 5;
    localparam int EBPFC_AREAS        = 8;
    localparam int EBPFC_PORTB_PINS   = 4;
    localparam int EBPFC_SEL7_POS     = 6;
    localparam int EBPFC_SEL6_POS     = 4;
    localparam int EBPFC_SEL5_POS     = 2;
    localparam int EBPFC_SEL_RSV_MSB  = 1;
    localparam int EBPFC_EXP_EN_POS   = 0;
    localparam int EBPFC_AWH_POS      = 8;

    // ------------------------------------------------------------
    // Reset values, pin-select codes and the 16-bit area width code
    // ------------------------------------------------------------
    localparam logic [7:0]  EBPFC_RST_CS_OUT_EN  = 8'h00;
    localparam logic [7:0]  EBPFC_RST_CS_PIN_SEL = 8'h00;
    localparam logic [4:0]  EBPFC_RST_UPPER_ADDR = 5'h00;
    localparam logic [15:0] EBPFC_RST_AREA_WIDTH = 16'h0000;
    localparam logic [1:0]  EBPFC_SEL_PIN_A      = 2'h0;
    localparam logic [1:0]  EBPFC_SEL_PIN_B      = 2'h1;
    localparam logic [1:0]  EBPFC_WIDTH_16       = 2'h1;

endpackage

/* rtl/ebpfc_strobe_router.sv */
// Routes chip-select strobes onto the four shared port B pins.
module ebpfc_strobe_router
    import ebpfc_pkg::*;
(
    // Control
    input  wire logic [7:0] cs_en,
    input  wire logic [7:0] pin_sel,
    input  wire logic       exp_en,
    // Strobes, active low
    input  wire logic [7:0] strobe_n,
    // Port B pin function
    output logic      [3:0] pin_oe,
    output logic      [3:0] pin_n
);

    // ------------------------------------------------------------
    // Pin-select decode
    // ------------------------------------------------------------
    // Bit 0 means pin A, bit 1 means pin B; prohibited codes select nothing.
    function automatic logic [1:0] ebpfc_sel_hit(input logic [1:0] code, input logic en);
        ebpfc_sel_hit = 2'h0;
        if (en && code == EBPFC_SEL_PIN_A)
            ebpfc_sel_hit = 2'h1;
        else if (en && code == EBPFC_SEL_PIN_B)
            ebpfc_sel_hit = 2'h2;
    endfunction

    logic [1:0] hit7;
    logic [1:0] hit6;
    logic [1:0] hit5;
    logic [7:0] act;
    logic [7:0] on;

    always_comb
    begin
        hit7 = ebpfc_sel_hit(pin_sel[EBPFC_SEL7_POS +: 2], cs_en[7]);
        hit6 = ebpfc_sel_hit(pin_sel[EBPFC_SEL6_POS +: 2], cs_en[6]);
        hit5 = ebpfc_sel_hit(pin_sel[EBPFC_SEL5_POS +: 2], cs_en[5]);
        on   = exp_en ? cs_en : 8'h00;
        act  = ~strobe_n;
        // Pin 3: strobe 3, strobe 7 on A.
        pin_oe[3] = on[3] | (exp_en & hit7[0]);
        pin_n[3]  = ~((on[3] & act[3]) | (exp_en & hit7[0] & act[7]));
        // Pin 2: strobe 2, strobe 6 on A.
        pin_oe[2] = on[2] | (exp_en & hit6[0]);
        pin_n[2]  = ~((on[2] & act[2]) | (exp_en & hit6[0] & act[6]));
        // Pin 1: strobe 1, strobe 5 on A, strobes 6 and 7 on B.
        pin_oe[1] = on[1] | (exp_en & (hit5[0] | hit6[1] | hit7[1]));
        pin_n[1]  = ~((on[1] & act[1]) | (exp_en & ((hit5[0] & act[5]) | (hit6[1] & act[6])
                    | (hit7[1] & act[7]))));
        // Pin 0: strobes 0 and 4, strobe 5 on B.
        pin_oe[0] = on[0] | on[4] | (exp_en & hit5[1]);
        pin_n[0]  = ~((on[0] & act[0]) | (on[4] & act[4]) | (exp_en & hit5[1] & act[5]));
    end

endmodule // ebpfc_strobe_router

/* rtl/ebpfc_top.sv */
// External bus pin function controller with its APB register file.
module ebpfc_top
    import ebpfc_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        ce,
    // Operating mode from the mode controller
    input  wire logic        ext_extended_mode,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic             pready,
    output logic      [31:0] prdata,
    output logic             pslverr,
    // Chip-select strobes from the bus controller, active low
    input  wire logic [7:0]  chip_strobe_n,
    // Pin functions
    output logic      [4:0]  portf_addr_oe,
    output logic      [7:0]  porth_data_sel,
    output logic      [7:0]  porti_data_sel,
    output logic      [3:0]  portb_strobe_oe,
    output logic      [3:0]  portb_strobe_n
);

    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic [7:0]  cs_en_q,       cs_en_d;
    logic [7:0]  cs_sel_q,      cs_sel_d;
    logic [4:0]  upper_en_q,    upper_en_d;
    logic [15:0] area_width_q,  area_width_d;
    logic        exp_en_q,      exp_en_d;
    logic        init_q,        init_d;
    logic        pready_q,      pready_d;
    logic [31:0] prdata_q,      prdata_d;
    logic        pslverr_q,     pslverr_d;
    logic        wr_go;
    logic        hit;
    logic [31:0] rd_val;

    // ------------------------------------------------------------
    // APB slave and register file
    // ------------------------------------------------------------
    always_comb
    begin
        hit = 1'b1;
        rd_val = 32'h0000_0000;
        unique case (paddr)
            EBPFC_OFS_CS_OUT_EN:  rd_val = {24'h000000, cs_en_q};
            EBPFC_OFS_CS_PIN_SEL: rd_val = {24'h000000, cs_sel_q[7:2], 2'h0};
            EBPFC_OFS_UPPER_ADDR: rd_val = {27'h0000000, upper_en_q};
            EBPFC_OFS_AREA_WIDTH: rd_val = {16'h0000, area_width_q};
            EBPFC_OFS_SYS_CTRL:   rd_val = {31'h00000000, exp_en_q};
            EBPFC_OFS_PIN_STATUS: rd_val = {17'h00000, portb_strobe_oe, porti_data_sel[0],
                                            porth_data_sel[0], portf_addr_oe, portb_strobe_n};
            default:              hit = 1'b0;
        endcase
    end

    assign wr_go = psel & penable & pready_q & pwrite & hit;

    always_comb
    begin
        pready_d  = psel & penable & ~pready_q;
        prdata_d  = prdata_q;
        pslverr_d = 1'b0;
        if (psel & penable & ~pready_q)
        begin
            prdata_d  = pwrite ? 32'h0000_0000 : rd_val;
            pslverr_d = ~hit;
        end
        cs_en_d      = cs_en_q;
        cs_sel_d     = cs_sel_q;
        upper_en_d   = upper_en_q;
        area_width_d = area_width_q;
        exp_en_d     = exp_en_q;
        init_d       = 1'b1;
        if (!init_q)
            cs_en_d[0] = ext_extended_mode;
        if (wr_go)
        begin
            unique case (paddr)
                EBPFC_OFS_CS_OUT_EN:  cs_en_d = pwdata[7:0];
                EBPFC_OFS_CS_PIN_SEL: cs_sel_d = {pwdata[7:2], 2'h0};
                EBPFC_OFS_UPPER_ADDR: upper_en_d = pwdata[4:0];
                EBPFC_OFS_AREA_WIDTH: area_width_d = pwdata[15:0];
                EBPFC_OFS_SYS_CTRL:   exp_en_d = pwdata[EBPFC_EXP_EN_POS];
                default:              exp_en_d = exp_en_q;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            cs_en_q      <= EBPFC_RST_CS_OUT_EN;
            cs_sel_q     <= EBPFC_RST_CS_PIN_SEL;
            upper_en_q   <= EBPFC_RST_UPPER_ADDR;
            area_width_q <= EBPFC_RST_AREA_WIDTH;
            exp_en_q     <= 1'b0;
            init_q       <= 1'b0;
            pready_q     <= 1'b0;
            prdata_q     <= 32'h0000_0000;
            pslverr_q    <= 1'b0;
        end
        else if (ce)
        begin
            cs_en_q      <= cs_en_d;
            cs_sel_q     <= cs_sel_d;
            upper_en_q   <= upper_en_d;
            area_width_q <= area_width_d;
            exp_en_q     <= exp_en_d;
            init_q       <= init_d;
            pready_q     <= pready_d;
            prdata_q     <= prdata_d;
            pslverr_q    <= pslverr_d;
        end
    end

    assign pready  = pready_q;
    assign prdata  = prdata_q;
    assign pslverr = pslverr_q;

    // ------------------------------------------------------------
    // Pin function outputs
    // ------------------------------------------------------------
    logic [4:0] addr_oe_q,  addr_oe_d;
    logic [7:0] dlo_q,      dlo_d;
    logic [7:0] dhi_q,      dhi_d;
    logic [3:0] pb_oe_q;
    logic [3:0] pb_n_q;
    logic [3:0] pb_oe_d;
    logic [3:0] pb_n_d;
    logic       wide16;

    ebpfc_strobe_router u_router
    (
        .cs_en    (cs_en_q),
        .pin_sel  (cs_sel_q),
        .exp_en   (exp_en_q),
        .strobe_n (chip_strobe_n),
        .pin_oe   (pb_oe_d),
        .pin_n    (pb_n_d)
    );

    always_comb
    begin
        wide16 = 1'b0;
        for (int i = 0; i < EBPFC_AREAS; i++)
            if ({area_width_q[EBPFC_AWH_POS + i], area_width_q[i]} == EBPFC_WIDTH_16)
                wide16 = 1'b1;
        addr_oe_d = exp_en_q ? upper_en_q : 5'h00;
        dlo_d     = {8{exp_en_q}};
        dhi_d     = {8{exp_en_q & wide16}};
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            addr_oe_q <= 5'h00;
            dlo_q     <= 8'h00;
            dhi_q     <= 8'h00;
            pb_oe_q   <= 4'h0;
            pb_n_q    <= 4'hF;
        end
        else if (ce)
        begin
            addr_oe_q <= addr_oe_d;
            dlo_q     <= dlo_d;
            dhi_q     <= dhi_d;
            pb_oe_q   <= pb_oe_d;
            pb_n_q    <= pb_n_d;
        end
    end

    assign portf_addr_oe   = addr_oe_q;
    assign porth_data_sel  = dlo_q;
    assign porti_data_sel  = dhi_q;
    assign portb_strobe_oe = pb_oe_q;
    assign portb_strobe_n  = pb_n_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    chk_upper_addr_oe: assert property ($past(ce) |-> portf_addr_oe == ($past(exp_en_q) ? $past(upper_en_q) : 5'h00))
        else $error("Upper address enable mismatch.");
    chk_low_data_lane: assert property ($past(ce) |-> porth_data_sel == {8{$past(exp_en_q)}})
        else $error("Low data lane selection mismatch.");
    chk_high_data_lane: assert property ($past(ce) && !$past(exp_en_q) |-> porti_data_sel == 8'h00)
        else $error("High data lanes selected without expansion.");
    chk_strobe3_io: assert property ($past(ce) && $past(exp_en_q) && !$past(cs_en_q[3]) && !$past(cs_en_q[7])
        |-> !portb_strobe_oe[3])
        else $error("Port B bit 3 taken with no strobe enabled.");
    chk_reset_enables: assert property ($rose(init_q) && !$past(wr_go) |-> cs_en_q[7:1] == 7'h00
        && cs_en_q[0] == $past(ext_extended_mode))
        else $error("Strobe enable reset value wrong.");
    chk_strobe7_route: assert property (ce && exp_en_q && cs_en_q == 8'h80 && cs_sel_q[7:6] == EBPFC_SEL_PIN_B
        && !chip_strobe_n[7] ##1 1'b1 |-> !portb_strobe_n[1] && portb_strobe_n[3])
        else $error("Strobe 7 not on port B bit 1.");
    chk_strobe6_route: assert property (ce && exp_en_q && cs_en_q == 8'h40 && cs_sel_q[5:4] == EBPFC_SEL_PIN_A
        && !chip_strobe_n[6] |=> !portb_strobe_n[2] && portb_strobe_n[1])
        else $error("Strobe 6 not on port B bit 2.");
    chk_strobe5_route: assert property (ce && exp_en_q && cs_en_q == 8'h20 && cs_sel_q[3:2] == EBPFC_SEL_PIN_B
        && !chip_strobe_n[5] |=> !portb_strobe_n[0] && portb_strobe_n[1])
        else $error("Strobe 5 not on port B bit 0.");
    chk_sel_no_effect: assert property (ce && cs_en_q[7:5] == 3'h0 && cs_en_q[3:0] == 4'h0 && !cs_en_q[4]
        |=> portb_strobe_oe == 4'h0 && portb_strobe_n == 4'hF)
        else $error("Pin select acted without enable.");
    chk_shared_pin: assert property (ce && exp_en_q && cs_en_q[1] && !chip_strobe_n[1]
        |=> !portb_strobe_n[1] && portb_strobe_oe[1])
        else $error("Shared pin missed an active strobe.");
    chk_rsv_read_zero: assert property (pready && !pslverr && !$past(pwrite) && $past(paddr) == EBPFC_OFS_CS_PIN_SEL
        |-> prdata[1:0] == 2'h0)
        else $error("Reserved pin-select bits read non-zero.");

    cov_strobe7_b: cover property (exp_en_q && cs_en_q[7] && cs_sel_q[7:6] == EBPFC_SEL_PIN_B);
    cov_shared_two: cover property (exp_en_q && cs_en_q[1] && cs_en_q[5] && cs_sel_q[3:2] == EBPFC_SEL_PIN_A);
    cov_wide_bus: cover property (porti_data_sel == 8'hFF);

endmodule // ebpfc_top

/* tb/ebpfc_mem_model.sv */
// Pin-side model of the external memories on the shared strobe pins.
module ebpfc_mem_model
(
    // Strobe pin functions from the device
    input  wire logic [3:0] portb_strobe_oe,
    input  wire logic [3:0] portb_strobe_n,
    // Pin levels seen by the memories
    output logic      [3:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    // A released pin is pulled up, so it reads high.
    always_comb
    begin
        for (int k = 0; k < 4; k++)
            pin_level[k] = portb_strobe_oe[k] ? portb_strobe_n[k] : 1'b1;
    end
endmodule // ebpfc_mem_model

/* tb/tb.sv */
// Self-checking testbench of the external bus pin function controller.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ebpfc_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        clock, rstn, ce, ext_extended_mode;
    logic        psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, chip_strobe_n, porth_data_sel, porti_data_sel;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0]  portf_addr_oe;
    logic [3:0]  portb_strobe_oe, portb_strobe_n, pin_level;
    logic        err;
    int          fails, total_checks, cyc;
    ebpfc_top dut (.clock(clock), .rstn(rstn), .ce(ce), .ext_extended_mode(ext_extended_mode),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .chip_strobe_n(chip_strobe_n),
        .portf_addr_oe(portf_addr_oe), .porth_data_sel(porth_data_sel), .porti_data_sel(porti_data_sel),
        .portb_strobe_oe(portb_strobe_oe), .portb_strobe_n(portb_strobe_n));
    ebpfc_mem_model mem (.portb_strobe_oe(portb_strobe_oe), .portb_strobe_n(portb_strobe_n),
        .pin_level(pin_level));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        $display("checks=%0d fails=%0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= wd;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 50)
        begin
            @(posedge clock);
            n++;
        end
        if (n == 50)
            chk(32'(pready), 32'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic settle();
        repeat (2) @(posedge clock);
        #1;
    endtask
    function automatic logic [7:0] pins(input logic [7:0] en, input logic [7:0] sel, input logic [7:0] s);
        logic [3:0] m [8];
        logic [3:0] oe;
        logic [3:0] n;
        m = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h1, 4'h0, 4'h0, 4'h0};
        m[5] = (sel[3:2] == 2'h0) ? 4'h2 : (sel[3:2] == 2'h1) ? 4'h1 : 4'h0;
        m[6] = (sel[5:4] == 2'h0) ? 4'h4 : (sel[5:4] == 2'h1) ? 4'h2 : 4'h0;
        m[7] = (sel[7:6] == 2'h0) ? 4'h8 : (sel[7:6] == 2'h1) ? 4'h2 : 4'h0;
        oe = 4'h0;
        n = 4'hF;
        for (int k = 0; k < 8; k++)
        begin
            if (en[k])
                oe |= m[k];
            if (en[k] && !s[k])
                n &= ~m[k];
        end
        return {oe, n};
    endfunction
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(EBPFC_OFS_CS_OUT_EN, 32'h1);
        rdc(EBPFC_OFS_CS_PIN_SEL, 32'h0);
        chk(32'(portb_strobe_oe), 32'h0);
        rstn <= 1'b0;
        ext_extended_mode <= 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        rdc(EBPFC_OFS_CS_OUT_EN, 32'h0);
        wr_sel_check();
    endtask
    task automatic wr_sel_check();
        apb(1'b1, EBPFC_OFS_CS_PIN_SEL, 32'h57);
        rdc(EBPFC_OFS_CS_PIN_SEL, 32'h54);
        apb(1'b0, 8'h18, 32'h0);
        chk(32'(err), 32'h1);
        chk(rd, 32'h0);
    endtask
    task automatic t_data();
        apb(1'b1, EBPFC_OFS_UPPER_ADDR, 32'h15);
        apb(1'b1, EBPFC_OFS_AREA_WIDTH, 32'h0008);
        settle();
        chk(32'(portf_addr_oe), 32'h0);
        chk(32'(porth_data_sel), 32'h0);
        chk(32'(porti_data_sel), 32'h0);
        apb(1'b1, EBPFC_OFS_SYS_CTRL, 32'h1);
        settle();
        chk(32'(portf_addr_oe), 32'h15);
        chk(32'(porth_data_sel), 32'hFF);
        chk(32'(porti_data_sel), 32'hFF);
        apb(1'b1, EBPFC_OFS_AREA_WIDTH, 32'h0808);
        apb(1'b1, EBPFC_OFS_UPPER_ADDR, 32'h0A);
        settle();
        chk(32'(porti_data_sel), 32'h0);
        chk(32'(portf_addr_oe), 32'h0A);
        rdc(EBPFC_OFS_PIN_STATUS, 32'h2AF);
    endtask
    task automatic t_route();
        logic [7:0] ens [3];
        logic [7:0] x;
        ens = '{8'hFF, 8'hE0, 8'h00};
        for (int e = 0; e < 3; e++)
        begin
            apb(1'b1, EBPFC_OFS_CS_OUT_EN, 32'(ens[e]));
            for (int c = 0; c < 64; c++)
            begin
                apb(1'b1, EBPFC_OFS_CS_PIN_SEL, 32'(c << 2));
                for (int k = 0; k < 9; k++)
                begin
                    chip_strobe_n <= (k == 8) ? 8'hFF : ~(8'h01 << k);
                    settle();
                    x = pins(ens[e], 8'(c << 2), chip_strobe_n);
                    chk(32'(portb_strobe_oe), 32'(x[7:4]));
                    chk(32'(pin_level), 32'(x[3:0]));
                end
            end
        end
    endtask
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial
    begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            fails++;
            end_sim();
        end
    end
    initial
    begin
        rstn = 1'b0;
        ce = 1'b1;
        ext_extended_mode = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        chip_strobe_n = 8'hFF;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
        t_reset();
        t_data();
        t_route();
        end_sim();
    end
endmodule // tb
